// [dv/mmspi_properties.sv]
module mmspi_properties #(
  parameter int GAP_RD = 100,
  parameter int GAP_WR = 200
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  import mmspi_pkg::*;
  // ---------------------------------------------------------------
  // byte tracking
  // ---------------------------------------------------------------
  logic        sck_d;
  logic        rd;
  logic        err;
  logic [2:0]  bit_cnt;
  logic [7:0]  idx;
  logic [7:0]  mi_sh;
  logic [15:0] gap;
  logic [15:0] low_cnt;
  logic [15:0] s1_cnt;
  logic        rise;
  logic [7:0]  rx_byte;
  assign rise    = sck && !sck_d && !ss_n;
  assign rx_byte = {mi_sh[6:0], miso};
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sck_d   <= 1'b1;
      rd      <= 1'b0;
      err     <= 1'b0;
      bit_cnt <= 3'h0;
      idx     <= 8'h00;
      mi_sh   <= 8'h00;
    end else begin
      sck_d <= sck;
      if (ss_n) begin
        bit_cnt <= 3'h0;
        idx     <= 8'h00;
        err     <= 1'b0;
      end else if (rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        mi_sh   <= rx_byte;
        if (bit_cnt == 3'h7) begin
          idx <= idx + 8'h01;
          if (idx == 8'h00) rd <= mosi;
          if (idx > 8'h02 && !rd && rx_byte == STAT_ERROR) err <= 1'b1;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // interval counters
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      gap     <= 16'hFFFF;
      low_cnt <= 16'h0000;
      s1_cnt  <= 16'h0000;
    end else begin
      gap     <= !ss_n ? 16'h0000 : (&gap ? gap : gap + 16'h0001);
      low_cnt <= sck ? 16'h0000 : low_cnt + 16'h0001;
      s1_cnt  <= ss_n ? 16'h0000 : (&s1_cnt ? s1_cnt : s1_cnt + 16'h0001);
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_NRST);
  sequence s_rise;
    !ss_n && $rose(sck);
  endsequence
  sequence s_byte_end;
    rise && bit_cnt == 3'h7 && miso_oe;
  endsequence
  property p_idle_high;
    ss_n |-> sck;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("clock not idle high while deselected");
  property p_mosi_hold;
    s_rise |-> $stable(mosi)[*8];
  endproperty
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("mosi moved after a rising clock");
  property p_miso_hold;
    s_rise |-> $stable(miso_out)[*8];
  endproperty
  a_miso_hold: assert property (p_miso_hold)
    else $error("miso moved after a rising clock");
  property p_sel_span;
    !sck |-> !ss_n;
  endproperty
  a_sel_span: assert property (p_sel_span)
    else $error("clock pulse outside select");
  property p_gap;
    $fell(ss_n) |-> gap >= (rd ? GAP_RD : GAP_WR);
  endproperty
  a_gap: assert property (p_gap)
    else $error("select gap too short");
  property p_header;
    s_byte_end ##0 idx < 8'h03 |-> rx_byte == STAT_DEFAULT;
  endproperty
  a_header: assert property (p_header)
    else $error("header byte not answered with default status");
  property p_wr_ack;
    s_byte_end ##0 (!rd && idx == 8'h03) |-> rx_byte == STAT_WRITE;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("write data byte not acknowledged");
  property p_err_sticky;
    s_byte_end ##0 (!rd && err) |-> rx_byte == STAT_ERROR;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error status not held to end of exchange");
  property p_oe_off;
    ss_n[*8] |-> !miso_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("miso driven while deselected");
  property p_setup;
    !ss_n && $fell(sck) && idx == 8'h00 && bit_cnt == 3'h0
      |-> s1_cnt >= S1_FREE_CYC;
  endproperty
  a_setup: assert property (p_setup)
    else $error("first clock too soon after select");
  property p_low_half;
    $rose(sck) |-> low_cnt >= HALF_CYC;
  endproperty
  a_low_half: assert property (p_low_half)
    else $error("clock low phase too short");
endmodule // mmspi_properties

// [dv/spi_memory_map_slave_tb_top.sv]
module spi_memory_map_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mmspi_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk = 1'b0, nrst = 1'b0, sleep = 1'b0, addr_ro = 1'b0;
  logic        rd_valid = 1'b0, wr_ready = 1'b0, msg_pend = 1'b0;
  logic        low_pow = 1'b0, start = 1'b0, read = 1'b0, tx_valid = 1'b0;
  logic [7:0]  rd_data = 8'h00, count = 8'h00, tx_data = 8'h00;
  logic [7:0]  wr_data, rx_data;
  logic [14:0] addr = 15'h0000, dev_addr, wr_addr;
  logic        deep_ok, rd_req, wr_valid, wr_drop, msg_read, tx_ready;
  logic        rx_valid, busy, change;
  int          n_fail = 0, n_tests = 0, n_msg = 0, n_drop = 0;
  logic [7:0]  rxq[$];
  logic [22:0] wq[$];
  logic [14:0] raq[$];
  always #12.5 clk = ~clk;
  // ---------------------------------------------------------------
  // design
  // ---------------------------------------------------------------
  mmspi_if i_mmspi_if ();
  mmspi_device #(.MSG_ADDR(15'h40FF)) i_mmspi_device (
    .I_CLK(clk), .I_NRST(nrst), .LINK(i_mmspi_if),
    .I_SLEEP(sleep), .O_DEEP_SLEEP_OK(deep_ok), .O_ADDR(dev_addr),
    .I_ADDR_RO(addr_ro), .O_RD_REQ(rd_req), .I_RD_VALID(rd_valid),
    .I_RD_DATA(rd_data), .O_WR_VALID(wr_valid), .O_WR_ADDR(wr_addr),
    .O_WR_DATA(wr_data), .I_WR_READY(wr_ready), .O_WR_DROP(wr_drop),
    .I_MSG_PENDING(msg_pend), .O_MSG_READ(msg_read));
  mmspi_host #(.GAP_RD(100), .GAP_WR(200)) i_mmspi_host (
    .I_CLK(clk), .I_NRST(nrst), .LINK(i_mmspi_if), .I_LOW_POWER(low_pow),
    .I_START(start), .I_READ(read), .I_ADDR(addr), .I_COUNT(count),
    .I_TX_VALID(tx_valid), .I_TX_DATA(tx_data), .O_TX_READY(tx_ready),
    .O_RX_VALID(rx_valid), .O_RX_DATA(rx_data), .O_BUSY(busy),
    .O_CHANGE(change));
  mmspi_properties #(.GAP_RD(100), .GAP_WR(200)) i_mmspi_properties (
    .I_CLK(clk), .I_NRST(nrst), .sck(i_mmspi_if.sck),
    .ss_n(i_mmspi_if.ss_n), .mosi(i_mmspi_if.mosi),
    .miso_out(i_mmspi_if.miso_out), .miso_oe(i_mmspi_if.miso_oe),
    .miso(i_mmspi_if.miso));
  // ---------------------------------------------------------------
  // user-side responders and monitors
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    rd_valid <= rd_req;
    if (rd_req) rd_data <= dev_addr[7:0] ^ 8'h3C;
    if (rd_req) raq.push_back(dev_addr);
    if (rx_valid) rxq.push_back(rx_data);
    if (wr_valid && wr_ready) wq.push_back({wr_addr, wr_data});
    if (tx_valid && tx_ready) tx_data <= tx_data + 8'h11;
    tx_valid <= !(tx_valid && tx_ready);
    if (msg_read) n_msg++;
    if (wr_drop) n_drop++;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic r, input logic [14:0] a,
                      input logic [7:0] c);
    int k;
    rxq.delete();
    @(posedge clk);
    start <= 1'b1;
    read  <= r;
    addr  <= a;
    count <= c;
    @(posedge clk);
    start <= 1'b0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (busy !== 1'b0 && k < 40000);
    if (k >= 40000) n_fail++;
  endtask
  task automatic chk_rx(input logic [47:0] e, input int n);
    check(rxq.size(), n);
    foreach (rxq[i]) if (i < n) check(rxq[i], e[8*(n-i)-1 -: 8]);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    #(CLK_NS * 95000);
    n_fail++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    low_pow <= 1'b1;
    tx_data <= 8'hC3;
    xfer(1'b0, 15'h2B4D, 8'h02);
    chk_rx(48'h555555AAAA, 5);
    check(wq.size(), 0);
    check(wr_valid, 1'b1);
    check({wr_addr, wr_data}, {15'h2B4D, 8'hC3});
    @(posedge clk);
    wr_ready <= 1'b1;
    repeat (4) @(posedge clk);
    check(wq.size(), 2);
    check(wr_valid, 1'b0);
    check(wq[0], {15'h2B4D, 8'hC3});
    check(wq[1], {15'h2B4E, 8'hD4});
    $display("test write done");
    low_pow <= 1'b0;
    msg_pend <= 1'b1;
    repeat (12) @(posedge clk);
    msg_pend <= 1'b0;
    check(change, 1'b1);
    xfer(1'b1, 15'h40FF, 8'h02);
    chk_rx(48'h555555C33C, 5);
    check(raq.size(), 2);
    check(raq[0], 15'h40FF);
    check(raq[1], 15'h4100);
    check(wq.size(), 2);
    check(n_msg, 1);
    check(change, 1'b0);
    $display("test read done");
    @(posedge clk);
    addr_ro <= 1'b1;
    xfer(1'b0, 15'h0003, 8'h03);
    chk_rx(48'h555555AAEEEE, 6);
    check(wq.size(), 2);
    check(n_drop, 0);
    $display("test read-only write done");
    @(posedge clk);
    addr_ro <= 1'b0;
    sleep <= 1'b1;
    xfer(1'b1, 15'h0010, 8'h00);
    chk_rx(48'hFFFFFF, 3);
    check(deep_ok, 1'b1);
    check(i_mmspi_if.miso_oe, 1'b0);
    check(i_mmspi_if.miso, 1'b1);
    @(posedge clk);
    sleep <= 1'b0;
    repeat (2) @(posedge clk);
    check(deep_ok, 1'b0);
    $display("test sleep done");
    end_sim;
  end
endmodule // spi_memory_map_slave_tb_top

// [logic/mmspi_device.sv]
module mmspi_device #(
  parameter int                             DEPTH    = mmspi_pkg::FIFO_DEPTH,
  parameter logic [mmspi_pkg::ADDR_W-1:0]   MSG_ADDR = '0
) (
  input  wire logic                         I_CLK,
  input  wire logic                         I_NRST,
  mmspi_if.device                           LINK,
  input  wire logic                         I_SLEEP,
  output logic                              O_DEEP_SLEEP_OK,
  output logic [mmspi_pkg::ADDR_W-1:0]      O_ADDR,
  input  wire logic                         I_ADDR_RO,
  output logic                              O_RD_REQ,
  input  wire logic                         I_RD_VALID,
  input  wire logic [7:0]                   I_RD_DATA,
  output logic                              O_WR_VALID,
  output logic [mmspi_pkg::ADDR_W-1:0]      O_WR_ADDR,
  output logic [7:0]                        O_WR_DATA,
  input  wire logic                         I_WR_READY,
  output logic                              O_WR_DROP,
  input  wire logic                         I_MSG_PENDING,
  output logic                              O_MSG_READ
);
  import mmspi_pkg::*;

  typedef enum logic [1:0] {PH_HDR, PH_DATA, PH_ERR} phase_t;

  logic              sck_m;
  logic              sck_s;
  logic              sck_d;
  logic              ss_m;
  logic              ss_s;
  logic              mosi_m;
  logic              mosi_s;
  logic              sel;
  logic              sck_rise;
  logic              sck_fall;
  logic [2:0]        bit_cnt;
  logic [7:0]        rx_sh;
  logic [7:0]        rx_byte;
  logic [1:0]        hdr_idx;
  phase_t            phase;
  logic              dir;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        remain;
  logic              byte_done;
  logic              wr_push;
  logic              fifo_ready;
  logic [7:0]        rd_buf;
  logic [7:0]        tx_sel;
  logic [7:0]        tx_sh;
  logic              miso_q;
  logic              oe_q;
  logic              pend_d;
  logic              msg_wait;
  logic              rd_start;

  // ---------------------------------------------------------------
  // pin synchronisers and edge detect
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sck_m  <= 1'b1;
      sck_s  <= 1'b1;
      sck_d  <= 1'b1;
      ss_m   <= 1'b1;
      ss_s   <= 1'b1;
      mosi_m <= 1'b0;
      mosi_s <= 1'b0;
    end else begin
      sck_m  <= LINK.sck;
      sck_s  <= sck_m;
      sck_d  <= sck_s;
      ss_m   <= LINK.ss_n;
      ss_s   <= ss_m;
      mosi_m <= LINK.mosi;
      mosi_s <= mosi_m;
    end
  end

  assign sel       = ~ss_s;                        // [R1]
  assign sck_rise  = sck_s & ~sck_d;               // [R2]
  assign sck_fall  = ~sck_s & sck_d;               // [R2]
  assign rx_byte   = {rx_sh[6:0], mosi_s};         // [R19]
  assign byte_done = sel & sck_rise & (bit_cnt == 3'd7);

  // ---------------------------------------------------------------
  // header decode and data phase
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      bit_cnt <= '0;
      rx_sh   <= '0;
      hdr_idx <= '0;
      phase   <= PH_HDR;
      dir     <= 1'b0;
      addr    <= '0;
      remain  <= '0;
    end else if (!sel) begin
      bit_cnt <= '0;                               // [R20]
      hdr_idx <= '0;                               // [R20]
      phase   <= PH_HDR;                           // [R20]
    end else if (sck_rise) begin
      rx_sh   <= rx_byte;
      bit_cnt <= bit_cnt + 3'd1;
      if (bit_cnt == 3'd7) begin
        unique case (phase)
          PH_HDR: begin                            // [R5]
            hdr_idx <= hdr_idx + 2'd1;
            unique case (hdr_idx)
              2'd0: begin
                dir       <= rx_byte[0];           // [R6]
                addr[6:0] <= rx_byte[7:1];         // [R7]
              end
              2'd1: addr[14:7] <= rx_byte;         // [R7]
              default: begin
                remain <= rx_byte;                 // [R8]
                phase  <= (rx_byte == 8'h00) ? PH_ERR : PH_DATA;
              end
            endcase
          end
          PH_DATA: begin
            if (!dir && (I_ADDR_RO || !fifo_ready)) begin
              phase <= PH_ERR;                     // [R14]
            end else begin
              addr   <= addr + 1'b1;               // [R9] [R10]
              remain <= remain - 8'd1;
              if (remain == 8'd1) begin
                phase <= PH_ERR;                   // [R13]
              end
            end
          end
          PH_ERR: phase <= PH_ERR;
          default: phase <= PH_ERR;
        endcase
      end
    end
  end

  assign O_ADDR  = addr;
  assign wr_push = byte_done & (phase == PH_DATA) & ~dir & ~I_ADDR_RO;

  // ---------------------------------------------------------------
  // write buffer toward the memory map
  // ---------------------------------------------------------------
  sync_fifo #(
    .WIDTH (ADDR_W + 8),
    .DEPTH (DEPTH)
  ) u_wr_fifo (
    .i_clk   (I_CLK),
    .i_nrst  (I_NRST),
    .i_valid (wr_push),                            // [R9]
    .o_ready (fifo_ready),
    .i_data  ({addr, rx_byte}),
    .o_valid (O_WR_VALID),
    .i_ready (I_WR_READY),
    .o_data  ({O_WR_ADDR, O_WR_DATA})
  );

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_WR_DROP <= 1'b0;
    end else begin
      O_WR_DROP <= wr_push & ~fifo_ready;
    end
  end

  // ---------------------------------------------------------------
  // read fetch, one byte ahead of the shifter
  // ---------------------------------------------------------------
  assign rd_start = byte_done & dir &
                    (((phase == PH_HDR) && (hdr_idx == 2'd2) &&
                      (rx_byte != 8'h00)) ||
                     ((phase == PH_DATA) && (remain != 8'd1)));

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_RD_REQ <= 1'b0;
      rd_buf   <= '0;
    end else begin
      O_RD_REQ <= rd_start;                        // [R10]
      if (I_RD_VALID) begin
        rd_buf <= I_RD_DATA;
      end
    end
  end

  // ---------------------------------------------------------------
  // outgoing byte
  // ---------------------------------------------------------------
  always_comb begin
    unique case (phase)
      PH_HDR:  tx_sel = STAT_DEFAULT;              // [R11]
      PH_DATA: tx_sel = dir ? rd_buf : STAT_WRITE; // [R10] [R12]
      PH_ERR:  tx_sel = STAT_ERROR;                // [R13] [R14]
      default: tx_sel = STAT_ERROR;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_sh  <= '0;
      miso_q <= 1'b1;
    end else if (!sel) begin
      tx_sh  <= '0;
      miso_q <= 1'b1;
    end else if (sck_fall) begin                   // [R2]
      if (bit_cnt == 3'd0) begin
        miso_q <= tx_sel[7];                       // [R19]
        tx_sh  <= {tx_sel[6:0], 1'b0};
      end else begin
        miso_q <= tx_sh[7];
        tx_sh  <= {tx_sh[6:0], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------
  // sleep handling
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      oe_q            <= 1'b0;
      O_DEEP_SLEEP_OK <= 1'b0;
    end else begin
      oe_q            <= sel & ~I_SLEEP;           // [R15]
      O_DEEP_SLEEP_OK <= I_SLEEP & ~sel;           // [R16]
    end
  end

  assign LINK.miso_out = miso_q;
  assign LINK.miso_oe  = oe_q;

  // ---------------------------------------------------------------
  // message waiting line
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pend_d     <= 1'b0;
      msg_wait   <= 1'b0;
      O_MSG_READ <= 1'b0;
    end else begin
      pend_d     <= I_MSG_PENDING;
      O_MSG_READ <= byte_done & dir & (phase == PH_DATA) &
                    (addr == MSG_ADDR);
      // a new message outranks the release of the old one
      msg_wait   <= (msg_wait & ~O_MSG_READ) |
                    (I_MSG_PENDING & ~pend_d);     // [R18]
    end
  end

  assign LINK.change_oe = msg_wait;
endmodule // mmspi_device

// [logic/mmspi_host.sv]
module mmspi_host #(
  parameter int GAP_RD = mmspi_pkg::GAP_RD_CYC,
  parameter int GAP_WR = mmspi_pkg::GAP_WR_CYC
) (
  input  wire logic                         I_CLK,
  input  wire logic                         I_NRST,
  mmspi_if.host                             LINK,
  input  wire logic                         I_LOW_POWER,
  input  wire logic                         I_START,
  input  wire logic                         I_READ,
  input  wire logic [mmspi_pkg::ADDR_W-1:0] I_ADDR,
  input  wire logic [7:0]                   I_COUNT,
  input  wire logic                         I_TX_VALID,
  input  wire logic [7:0]                   I_TX_DATA,
  output logic                              O_TX_READY,
  output logic                              O_RX_VALID,
  output logic [7:0]                        O_RX_DATA,
  output logic                              O_BUSY,
  output logic                              O_CHANGE
);
  import mmspi_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_LOAD, H_LOW, H_HIGH, H_BGAP, H_HOLD, H_GAP
  } hstate_t;

  hstate_t           st;
  logic [19:0]       cnt;
  logic [2:0]        bit_cnt;
  logic [8:0]        idx;
  logic              rd;
  logic [7:0]        count;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        tx_sh;
  logic [7:0]        rx_sh;
  logic [7:0]        nbyte;
  logic              miso_m;
  logic              miso_s;
  logic              chg_m;
  logic              chg_s;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      miso_m <= 1'b1;
      miso_s <= 1'b1;
      chg_m  <= 1'b1;
      chg_s  <= 1'b1;
    end else begin
      miso_m <= LINK.miso;
      miso_s <= miso_m;
      chg_m  <= LINK.change_n;
      chg_s  <= chg_m;
    end
  end

  always_comb begin
    unique case (idx)
      9'd0:    nbyte = {addr[6:0], rd};            // [R6] [R7]
      9'd1:    nbyte = addr[14:7];                 // [R7]
      9'd2:    nbyte = count;                      // [R8]
      default: nbyte = rd ? 8'h00 : I_TX_DATA;
    endcase
  end

  assign O_TX_READY = (st == H_LOAD) & ~rd & (idx >= 9'(HDR_BYTES));
  assign O_BUSY     = (st != H_IDLE);
  assign O_CHANGE   = ~chg_s;

  // ---------------------------------------------------------------
  // exchange sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      st         <= H_IDLE;
      cnt        <= '0;
      bit_cnt    <= '0;
      idx        <= '0;
      rd         <= 1'b0;
      count      <= '0;
      addr       <= '0;
      tx_sh      <= '0;
      rx_sh      <= '0;
      LINK.sck   <= 1'b1;                          // [R2]
      LINK.ss_n  <= 1'b1;
      LINK.mosi  <= 1'b1;
      O_RX_VALID <= 1'b0;
      O_RX_DATA  <= '0;
    end else begin
      O_RX_VALID <= 1'b0;
      if (cnt != 20'd0) begin
        cnt <= cnt - 20'd1;
      end
      unique case (st)
        H_IDLE: if (I_START) begin
          rd        <= I_READ;
          addr      <= I_ADDR;
          count     <= I_COUNT;
          idx       <= '0;
          LINK.ss_n <= 1'b0;                       // [R3]
          cnt       <= I_LOW_POWER ? 20'(S1_LP_CYC - 1)
                                   : 20'(S1_FREE_CYC - 1); // [R17]
          st        <= H_SETUP;
        end
        H_SETUP, H_BGAP: if (cnt == 20'd0) begin
          st <= H_LOAD;
        end
        H_LOAD: if (rd || idx < 9'(HDR_BYTES) || I_TX_VALID) begin
          tx_sh     <= {nbyte[6:0], 1'b0};
          LINK.mosi <= nbyte[7];                   // [R19]
          LINK.sck  <= 1'b0;                       // [R2]
          bit_cnt   <= '0;
          cnt       <= 20'(HALF_CYC - 1);
          st        <= H_LOW;
        end
        H_LOW: if (cnt == 20'd0) begin
          LINK.sck <= 1'b1;
          rx_sh    <= {rx_sh[6:0], miso_s};        // [R2]
          cnt      <= 20'(HALF_CYC - 1);
          st       <= H_HIGH;
        end
        H_HIGH: if (cnt == 20'd0) begin
          if (bit_cnt == 3'd7) begin               // [R1]
            O_RX_VALID <= 1'b1;
            O_RX_DATA  <= rx_sh;
            idx        <= idx + 9'd1;
            if (idx + 9'd1 == 9'(HDR_BYTES) + {1'b0, count}) begin
              cnt <= 20'(S2_CYC - 1);
              st  <= H_HOLD;
            end else begin
              cnt <= 20'(BGAP_CYC - 1);
              st  <= H_BGAP;
            end
          end else begin
            bit_cnt   <= bit_cnt + 3'd1;
            LINK.sck  <= 1'b0;
            LINK.mosi <= tx_sh[7];
            tx_sh     <= {tx_sh[6:0], 1'b0};
            cnt       <= 20'(HALF_CYC - 1);
            st        <= H_LOW;
          end
        end
        H_HOLD: if (cnt == 20'd0) begin
          LINK.ss_n <= 1'b1;                       // [R3]
          cnt       <= rd ? 20'(GAP_RD - 1) : 20'(GAP_WR - 1); // [R4]
          st        <= H_GAP;
        end
        H_GAP: if (cnt == 20'd0) begin
          st <= H_IDLE;
        end
      endcase
    end
  end
endmodule // mmspi_host

// [logic/mmspi_if.sv]
interface mmspi_if;
  logic sck;
  logic ss_n;
  logic mosi;
  logic miso_out;
  logic miso_oe;
  logic change_oe;
  logic miso;
  logic change_n;
  // ---------------------------------------------------------------
  // wire levels, undriven lines read as pulled up
  // ---------------------------------------------------------------
  assign miso     = miso_oe ? miso_out : 1'b1;
  assign change_n = change_oe ? 1'b0 : 1'b1;
  modport device (input sck, ss_n, mosi,
                  output miso_out, miso_oe, change_oe);
  modport host   (output sck, ss_n, mosi, input miso, change_n);
endinterface : mmspi_if

// [logic/mmspi_pkg.sv]
// How it works
// R1 - slave only, full duplex, host clocks
// R2 - clock idles high, change fall, sample rise
// R3 - host holds select low whole exchange
// R4 - select high 2 ms after read, 10 ms after write
// R5 - three header bytes start every exchange
// R6 - header byte 0 bit 0: 1 read
// R7 - address low 7 bits, then upper 8
// R8 - third header byte gives data count
// R9 - written bytes go to rising addresses
// R10 - read returns rising addresses, ignores host bytes
// R11 - header bytes answered with 0x55
// R12 - write data bytes answered with 0xAA
// R13 - bytes past the count answered 0xEE
// R14 - read-only target: 0xEE, rest discarded
// R15 - output undriven while device sleeps
// R16 - deep sleep only with select high
// R17 - host waits after select before clocking
// R18 - message line released on read, reasserted
// R19 - bytes go most significant bit first
// R20 - select high resets the exchange
package mmspi_pkg;
  // ---------------------------------------------------------------
  // framing
  // ---------------------------------------------------------------
  localparam int         ADDR_W       = 15;
  localparam int         HDR_BYTES    = 3;
  localparam logic [7:0] STAT_DEFAULT = 8'h55;
  localparam logic [7:0] STAT_WRITE   = 8'hAA;
  localparam logic [7:0] STAT_ERROR   = 8'hEE;
  localparam int         FIFO_DEPTH   = 32;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS       = 25;
  localparam int T_HALF_NS    = 666;
  localparam int T_S1_FREE_NS = 2000;
  localparam int T_S1_LP_NS   = 22000;
  localparam int T_S2_NS      = 20000;
  localparam int T_BGAP_NS    = 100000;
  localparam int T_GAP_RD_NS  = 2000000;
  localparam int T_GAP_WR_NS  = 10000000;
  localparam int HALF_CYC     = (T_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int S1_FREE_CYC  = (T_S1_FREE_NS + CLK_NS - 1) / CLK_NS;
  localparam int S1_LP_CYC    = T_S1_LP_NS / CLK_NS + 1;
  localparam int S2_CYC       = (T_S2_NS + CLK_NS - 1) / CLK_NS;
  localparam int BGAP_CYC     = (T_BGAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_RD_CYC   = (T_GAP_RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_WR_CYC   = (T_GAP_WR_NS + CLK_NS - 1) / CLK_NS;
endpackage : mmspi_pkg

// [logic/sync_fifo.sv]
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;

  assign empty   = (wr_ptr == rd_ptr);
  assign full    = (wr_ptr[AW] != rd_ptr[AW]) &&
                   (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign o_ready = ~full;
  assign o_valid = ~empty;
  assign o_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge i_clk) begin
    if (i_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (i_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (i_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // sync_fifo
